// [rtl/esp_defs.svh]
// constants for the edge separation and pulse counter channel
`ifndef ESP_DEFS_SVH
`define ESP_DEFS_SVH
// Notes on behaviour
// - counting of timebase edges starts on a start edge and stops on a gate edge
// - nothing is measured before arming; earlier edges have no effect
// - further start edges are ignored while a count is running
// - the stopping gate edge ends counting and pushes the count into the FIFO, except in sample-clocked mode where it is held
// - start, gate and timebase active edges each selectable rising or falling
// - single measurement keeps its one count and ignores all later edges
// - implicit buffered measurement waits for a new start edge after each gate edge, every count streamed out
// - sample-clocked measurement writes the latest finished count on a sample clock edge
// - overrun when no complete start and gate pair lands between sample clocks
// - single pulse waits the delay after arming, then holds the programmed width
// - triggered single pulse gives one pulse on the first trigger after arming, delay counted from trigger
// - finite train counts emitted pulses and stops at the programmed number
// - retriggerable mode launches per gate trigger, ignores gate while generating
// - delay on every trigger or first only; default on for single, off for trains
// - pause configuration refused for retriggered generation
// - continuous train alternates high and low phases, starts on arm or trigger
// - gate used as pause suspends generation while it is at its active level
// - continuous output frequency is timebase frequency over high plus low lengths
// - implicit buffered train takes idle and active lengths from each FIFO sample
// - sample-clocked train uses static settings until the first sample clock
// - a sample clock lets the running idle-then-active pulse finish first
// - the channel counters are 32 bits wide and independent
`define ESP_CNT_W 32
`define ESP_SPEC_W 64
`define ESP_IDLE_LSB 32
`define ESP_ACTIVE_LSB 0
`define ESP_FIFO_DEPTH 16
`define ESP_NPINS 4
`define ESP_PIN_START 0
`define ESP_PIN_GATE 1
`define ESP_PIN_TB 2
`define ESP_PIN_SAMPLE 3
`define ESP_MIN_TRIG_TICKS 2
`define ESP_RESET_STATE '0
`endif

// [rtl/esp_pkg.sv]
// types for the edge separation and pulse counter channel
`include "esp_defs.svh"
package esp_pkg;
    typedef enum logic [3:0] {
        esp_meas_single, esp_meas_implicit, esp_meas_sampled,
        esp_gen_single, esp_gen_trig_single, esp_gen_finite, esp_gen_retrig,
        esp_gen_cont, esp_gen_buf_implicit, esp_gen_buf_sampled
    } esp_mode_t;

    typedef enum logic [3:0] {
        esp_st_idle, esp_st_wait_start, esp_st_count, esp_st_done,
        esp_st_wait_trig, esp_st_delay, esp_st_high, esp_st_low, esp_st_fetch
    } esp_phase_t;

    typedef struct packed {
        logic [`ESP_NPINS-1:0] s1;
        logic [`ESP_NPINS-1:0] s2;
        logic [`ESP_NPINS-1:0] s3;
        logic [`ESP_NPINS-1:0] filt;
        logic arm_q;
        esp_phase_t state;
        logic [`ESP_CNT_W-1:0] cnt;
        logic [`ESP_CNT_W-1:0] pulses;
        logic [`ESP_CNT_W-1:0] cur_low;
        logic [`ESP_CNT_W-1:0] cur_high;
        logic [`ESP_CNT_W-1:0] hold;
        logic [`ESP_CNT_W-1:0] last_count;
        logic hold_valid;
        logic samp_pend;
        logic first_trig;
        logic pulse_out;
        logic done;
        logic overrun;
        logic underflow;
        logic overflow;
        logic cfg_err;
    } esp_state_t;
endpackage : esp_pkg

// [rtl/esp_counter.sv]
// counter channel: edge separation measurement and pulse generation, with its FIFO
`timescale 1ns/1ps
`include "esp_defs.svh"

module esp_fifo #(
    parameter int WIDTH = `ESP_SPEC_W,
    parameter int DEPTH = `ESP_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad_params
        $error("esp_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } esp_fifo_state_t;

    esp_fifo_state_t r;
    esp_fifo_state_t n;
    logic wr;
    logic rd;

    assign in_ready = r.cnt != (AW + 1)'(DEPTH);
    assign out_valid = r.cnt != '0;
    assign out_data = r.mem[r.rp];
    assign wr = in_valid && in_ready;
    assign rd = out_valid && out_ready;

    always_comb
    begin
        n = r;
        if (wr)
        begin
            n.mem[r.wp] = in_data;
            n.wp = AW'(r.wp + 1'b1);
        end
        if (rd)
            n.rp = AW'(r.rp + 1'b1);
        case ({wr, rd})
            2'b10: n.cnt = (AW + 1)'(r.cnt + 1'b1);
            2'b01: n.cnt = (AW + 1)'(r.cnt - 1'b1);
            default: n.cnt = r.cnt;
        endcase
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            r <= `ESP_RESET_STATE;
        else
            r <= n;
    end
endmodule : esp_fifo

module esp_counter #(
    parameter int FIFO_DEPTH = `ESP_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // counter pins
    input wire logic start_edge_in,
    input wire logic gate_in,
    input wire logic timebase_in,
    input wire logic sample_clk_in,
    output logic pulse_out,
    // configuration
    input wire logic arm,
    input wire esp_pkg::esp_mode_t mode,
    input wire logic start_rise,
    input wire logic gate_rise,
    input wire logic timebase_rise,
    input wire logic sample_rise,
    input wire logic use_start_trigger,
    input wire logic gate_is_pause,
    input wire logic delay_every_override,
    input wire logic delay_every_trigger_setting,
    input wire logic [`ESP_CNT_W-1:0] delay_ticks,
    input wire logic [`ESP_CNT_W-1:0] high_ticks,
    input wire logic [`ESP_CNT_W-1:0] low_ticks,
    input wire logic [`ESP_CNT_W-1:0] pulse_count,
    // status
    output logic busy,
    output logic done,
    output logic [`ESP_CNT_W-1:0] last_count,
    output logic overrun_err,
    output logic underflow_err,
    output logic overflow_err,
    output logic config_err,
    // pulse specification stream in
    input wire logic spec_valid,
    input wire logic [`ESP_SPEC_W-1:0] spec_data,
    output logic spec_ready,
    // measurement result stream out
    output logic res_valid,
    output logic [`ESP_CNT_W-1:0] res_data,
    input wire logic res_ready
);
    import esp_pkg::*;

    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("esp_counter: FIFO depth must be a power of two of at least 2");
    end

    function automatic logic [`ESP_CNT_W-1:0] esp_len(input logic [`ESP_CNT_W-1:0] x);
        return (x == '0) ? `ESP_CNT_W'(1) : x;
    endfunction : esp_len

    function automatic logic esp_pick(input logic rise_sel, input logic r_ev, input logic f_ev);
        return rise_sel ? r_ev : f_ev;
    endfunction : esp_pick

    esp_state_t r;
    esp_state_t n;
    logic [`ESP_NPINS-1:0] chg;
    logic [`ESP_NPINS-1:0] rise;
    logic [`ESP_NPINS-1:0] fall;
    logic start_evt;
    logic gate_evt;
    logic tb_tick;
    logic samp_evt;
    logic arm_evt;
    logic meas_mode;
    logic buf_gen;
    logic gate_trig;
    logic paused;
    logic tick_en;
    logic pause_conflict;
    logic delay_every;
    logic push;
    logic [`ESP_CNT_W-1:0] push_data;
    logic pop;
    logic f_in_valid;
    logic [`ESP_SPEC_W-1:0] f_in_data;
    logic f_in_ready;
    logic f_out_valid;
    logic [`ESP_SPEC_W-1:0] f_out_data;
    logic f_out_ready;
    logic [`ESP_CNT_W-1:0] pulses_inc;

    // a level change counts once the second and third stages agree
    assign chg = ~(r.s2 ^ r.s3) & (r.s3 ^ r.filt);
    assign rise = chg & r.s3;
    assign fall = chg & ~r.s3;
    assign start_evt = esp_pick(start_rise, rise[`ESP_PIN_START], fall[`ESP_PIN_START]);
    assign gate_evt = esp_pick(gate_rise, rise[`ESP_PIN_GATE], fall[`ESP_PIN_GATE]);
    assign tb_tick = esp_pick(timebase_rise, rise[`ESP_PIN_TB], fall[`ESP_PIN_TB]);
    assign samp_evt = esp_pick(sample_rise, rise[`ESP_PIN_SAMPLE], fall[`ESP_PIN_SAMPLE]);
    assign arm_evt = arm && !r.arm_q;

    assign meas_mode = mode inside {esp_meas_single, esp_meas_implicit, esp_meas_sampled};
    assign buf_gen = mode inside {esp_gen_buf_implicit, esp_gen_buf_sampled};
    assign gate_trig = mode inside {esp_gen_trig_single, esp_gen_retrig}
        || (mode == esp_gen_cont && use_start_trigger);
    assign pause_conflict = gate_is_pause && mode == esp_gen_retrig;
    // pause holds while the gate sits at its active level
    assign paused = gate_is_pause && !gate_trig && !meas_mode
        && (r.filt[`ESP_PIN_GATE] == gate_rise);
    assign tick_en = tb_tick && !paused;
    // without override, delay repeats for single pulses and not for trains
    assign delay_every = delay_every_override ? delay_every_trigger_setting
        : (pulse_count <= `ESP_CNT_W'(1));
    assign pulses_inc = r.pulses + `ESP_CNT_W'(1);

    // the one FIFO carries results out when measuring, pulse specs in for buffered generation
    assign f_in_valid = buf_gen ? spec_valid : push;
    assign f_in_data = buf_gen ? spec_data : {`ESP_CNT_W'(0), push_data};
    assign spec_ready = buf_gen && f_in_ready;
    assign res_valid = meas_mode && f_out_valid;
    assign res_data = f_out_data[`ESP_CNT_W-1:0];
    assign f_out_ready = meas_mode ? res_ready : pop;

    assign pulse_out = r.pulse_out;
    assign busy = !(r.state inside {esp_st_idle, esp_st_done});
    assign done = r.done;
    assign last_count = r.last_count;
    assign overrun_err = r.overrun;
    assign underflow_err = r.underflow;
    assign overflow_err = r.overflow;
    assign config_err = r.cfg_err;

    esp_fifo #(
        .WIDTH(`ESP_SPEC_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_valid(f_in_valid),
        .in_data(f_in_data),
        .in_ready(f_in_ready),
        .out_valid(f_out_valid),
        .out_data(f_out_data),
        .out_ready(f_out_ready)
    );

    always_comb
    begin
        n = r;
        push = 1'b0;
        push_data = r.cnt;
        pop = 1'b0;
        n.s1 = {sample_clk_in, timebase_in, gate_in, start_edge_in};
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.filt = (r.filt & ~chg) | (r.s3 & chg);
        n.arm_q = arm;
        n.cfg_err = pause_conflict;
        // sample clock moves a finished count out, or flags a missing pair
        if (arm && mode == esp_meas_sampled && r.state != esp_st_idle && samp_evt)
        begin
            if (r.hold_valid)
            begin
                push = 1'b1;
                push_data = r.hold;
                n.hold_valid = 1'b0;
            end
            else
                n.overrun = 1'b1;
        end
        if (!arm)
        begin
            n.state = esp_st_idle;
            n.hold_valid = 1'b0;
            n.samp_pend = 1'b0;
        end
        else
        begin
            case (r.state)
                esp_st_idle:
                    if (arm_evt && !pause_conflict)
                    begin
                        n.done = 1'b0;
                        n.overrun = 1'b0;
                        n.underflow = 1'b0;
                        n.overflow = 1'b0;
                        n.pulses = '0;
                        n.first_trig = 1'b1;
                        n.cur_low = low_ticks;
                        n.cur_high = high_ticks;
                        if (meas_mode)
                            n.state = esp_st_wait_start;
                        else if (gate_trig)
                            n.state = esp_st_wait_trig;
                        else if (mode == esp_gen_buf_implicit)
                            n.state = esp_st_fetch;
                        else if (delay_ticks != '0)
                        begin
                            n.state = esp_st_delay;
                            n.cnt = delay_ticks;
                        end
                        else
                        begin
                            n.state = esp_st_high;
                            n.cnt = esp_len(high_ticks);
                        end
                    end
                esp_st_wait_start:
                    if (start_evt)
                    begin
                        n.state = esp_st_count;
                        n.cnt = '0;
                    end
                esp_st_count:
                    if (gate_evt)
                    begin
                        n.last_count = r.cnt;
                        if (mode == esp_meas_sampled)
                        begin
                            n.hold = r.cnt;
                            n.hold_valid = 1'b1;
                        end
                        else
                            push = 1'b1;
                        if (mode == esp_meas_single)
                        begin
                            n.state = esp_st_done;
                            n.done = 1'b1;
                        end
                        else
                            n.state = esp_st_wait_start;
                    end
                    else if (tb_tick)
                        n.cnt = r.cnt + `ESP_CNT_W'(1);
                esp_st_wait_trig:
                    if (gate_evt)
                    begin
                        n.first_trig = 1'b0;
                        n.pulses = '0;
                        if ((r.first_trig || delay_every) && delay_ticks != '0)
                        begin
                            n.state = esp_st_delay;
                            n.cnt = delay_ticks;
                        end
                        else
                        begin
                            n.state = esp_st_high;
                            n.cnt = esp_len(r.cur_high);
                        end
                    end
                esp_st_delay:
                    if (tick_en)
                    begin
                        if (r.cnt <= `ESP_CNT_W'(1))
                        begin
                            n.state = esp_st_high;
                            n.cnt = esp_len(r.cur_high);
                        end
                        else
                            n.cnt = r.cnt - `ESP_CNT_W'(1);
                    end
                esp_st_low:
                    if (tick_en)
                    begin
                        if (r.cnt <= `ESP_CNT_W'(1))
                        begin
                            n.state = esp_st_high;
                            n.cnt = esp_len(r.cur_high);
                        end
                        else
                            n.cnt = r.cnt - `ESP_CNT_W'(1);
                    end
                esp_st_high:
                    if (tick_en && r.cnt > `ESP_CNT_W'(1))
                        n.cnt = r.cnt - `ESP_CNT_W'(1);
                    else if (tick_en)
                    begin
                        n.pulses = pulses_inc;
                        n.state = esp_st_low;
                        n.cnt = esp_len(r.cur_low);
                        case (mode)
                            esp_gen_single, esp_gen_trig_single:
                            begin
                                n.state = esp_st_done;
                                n.done = 1'b1;
                            end
                            esp_gen_finite:
                                if (pulses_inc >= esp_len(pulse_count))
                                begin
                                    n.state = esp_st_done;
                                    n.done = 1'b1;
                                end
                            esp_gen_retrig:
                                if (pulses_inc >= esp_len(pulse_count))
                                    n.state = esp_st_wait_trig;
                            esp_gen_buf_implicit:
                                n.state = esp_st_fetch;
                            esp_gen_buf_sampled:
                                if (r.samp_pend)
                                begin
                                    n.samp_pend = 1'b0;
                                    if (f_out_valid)
                                    begin
                                        pop = 1'b1;
                                        n.cur_low = f_out_data[`ESP_IDLE_LSB +: `ESP_CNT_W];
                                        n.cur_high = f_out_data[`ESP_ACTIVE_LSB +: `ESP_CNT_W];
                                        n.cnt = esp_len(f_out_data[`ESP_IDLE_LSB +: `ESP_CNT_W]);
                                    end
                                    else
                                        n.underflow = 1'b1;
                                end
                            default:
                                n.state = esp_st_low;
                        endcase
                    end
                esp_st_fetch:
                    if (f_out_valid)
                    begin
                        pop = 1'b1;
                        n.cur_low = f_out_data[`ESP_IDLE_LSB +: `ESP_CNT_W];
                        n.cur_high = f_out_data[`ESP_ACTIVE_LSB +: `ESP_CNT_W];
                        n.cnt = esp_len(f_out_data[`ESP_IDLE_LSB +: `ESP_CNT_W]);
                        n.state = esp_st_low;
                    end
                    else if (r.pulses != '0)
                    begin
                        n.underflow = 1'b1;
                        n.state = esp_st_done;
                        n.done = 1'b1;
                    end
                default:
                    n.state = r.state;
            endcase
            if (mode == esp_gen_buf_sampled && samp_evt && r.state != esp_st_idle)
                n.samp_pend = 1'b1;
        end
        if (push && !f_in_ready)
            n.overflow = 1'b1;
        n.pulse_out = n.state == esp_st_high;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            r <= `ESP_RESET_STATE;
        else
            r <= n;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_count_running;
        arm && r.state == esp_st_count;
    endsequence
    sequence s_stop_edge;
        s_count_running ##0 gate_evt;
    endsequence
    sequence s_high_last_tick;
        arm && r.state == esp_st_high && tick_en && r.cnt <= `ESP_CNT_W'(1);
    endsequence

    count_start_a: assert property ((arm && r.state == esp_st_wait_start && start_evt) |=>
        (r.state == esp_st_count && r.cnt == '0))
        else $error("start edge did not begin a count from zero");
    count_only_armed_a: assert property ($rose(r.state == esp_st_count) |->
        $past(r.state == esp_st_wait_start && start_evt))
        else $error("count began without an armed start edge");
    start_ignored_a: assert property ((s_count_running ##0 (start_evt && !gate_evt && !tb_tick)) |=>
        (r.state == esp_st_count && $stable(r.cnt)))
        else $error("start edge disturbed a running count");
    tick_count_a: assert property ((s_count_running ##0 (tb_tick && !gate_evt)) |=>
        r.cnt == $past(r.cnt) + `ESP_CNT_W'(1))
        else $error("timebase edge not counted");
    stop_store_a: assert property ((s_stop_edge ##0 (mode != esp_meas_sampled)) |->
        (push && push_data == r.cnt) ##1 (r.state != esp_st_count && r.last_count == $past(r.cnt)))
        else $error("stopping gate edge did not store the count");
    single_hold_a: assert property ((arm && r.state == esp_st_done) |=>
        (r.state == esp_st_done && $stable(r.last_count)))
        else $error("finished single operation moved on");
    sampled_hold_a: assert property ((s_stop_edge ##0 (mode == esp_meas_sampled)) |=>
        (r.hold_valid && r.hold == $past(r.cnt)))
        else $error("sampled count not held for the sample clock");
    overrun_flag_a: assert property ((arm && mode == esp_meas_sampled && r.state != esp_st_idle
        && samp_evt && !r.hold_valid) |=> overrun_err)
        else $error("missing pair between sample clocks not flagged");
    pulse_end_a: assert property (s_high_last_tick |=> !pulse_out)
        else $error("output stayed active past its width");
    pause_hold_a: assert property ((arm && paused && r.state inside {esp_st_high, esp_st_low, esp_st_delay})
        |=> ($stable(r.cnt) && r.state == $past(r.state)))
        else $error("generation advanced while paused");
    retrig_refuse_a: assert property ((arm_evt && r.state == esp_st_idle && pause_conflict) |=>
        (r.state == esp_st_idle && config_err))
        else $error("pause configuration accepted in retriggered mode");
    underflow_flag_a: assert property ((s_high_last_tick ##0 (mode == esp_gen_buf_sampled
        && r.samp_pend && !f_out_valid)) |=> underflow_err)
        else $error("empty FIFO at reload not flagged");
    disarm_idle_a: assert property (!arm |=> (!pulse_out && r.state == esp_st_idle))
        else $error("disarm did not return the output to idle");
endmodule : esp_counter

// [tb/esp_pin_model.sv]
// far-side pin model: start-edge, gate and timebase drivers
`timescale 1ns/1ps
module esp_pin_model (
    // clock
    input wire logic clock,
    // pins
    output logic start_edge,
    output logic gate,
    output logic timebase,
    output logic sample_clk
);
    initial
    begin
        start_edge = 1'b0;
        gate = 1'b0;
        timebase = 1'b0;
        sample_clk = 1'b0;
    end
    // n timebase pulses per call, levels held long enough for the filter
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clock) timebase <= 1'b1;
            repeat (4) @(posedge clock);
            timebase <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask : tick
    // g selects the pin: 0 start edge, 1 gate, 2 sample clock
    task automatic pulse(input int g);
        @(posedge clock);
        start_edge <= g == 0;
        gate <= g == 1;
        sample_clk <= g == 2;
        repeat (4) @(posedge clock);
        gate <= 1'b0;
        start_edge <= 1'b0;
        sample_clk <= 1'b0;
        repeat (16) @(posedge clock);
    endtask : pulse
endmodule : esp_pin_model

// [tb/tb_esp_counter.sv]
// testbench for the counter channel
`timescale 1ns/1ps
module tb_esp_counter;
    import esp_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, arm = 1'b0, res_ready = 1'b0, spec_valid = 1'b0, s1 = 1'b1, s0 = 1'b0;
    logic sr = 1'b1, gr = 1'b1, ust = 1'b0, pz = 1'b0, sample_clk_in;
    logic start_edge_in, gate_in, timebase_in, pulse_out, busy, done, ovr, und, ovf, cfg, spec_ready, res_valid;
    logic [31:0] dly = 32'h0, hi = 32'h1, lo = 32'h1, pc = 32'h1, last_count, res_data;
    logic [63:0] spec_data = {32'h1, 32'h1};
    esp_mode_t mode = esp_meas_single;
    int num_errors = 0, num_checks = 0, n, f;
    always #5 clock = ~clock;
    esp_pin_model pins (.clock, .start_edge(start_edge_in), .gate(gate_in), .timebase(timebase_in),
        .sample_clk(sample_clk_in));
    esp_counter dut (.clock, .resetn, .start_edge_in, .gate_in, .timebase_in, .sample_clk_in, .pulse_out,
        .arm, .mode, .start_rise(sr), .gate_rise(gr), .timebase_rise(s1), .sample_rise(s1),
        .use_start_trigger(ust), .gate_is_pause(pz), .delay_every_override(s0), .delay_every_trigger_setting(s0),
        .delay_ticks(dly), .high_ticks(hi), .low_ticks(lo), .pulse_count(pc), .busy, .done, .last_count,
        .overrun_err(ovr), .underflow_err(und), .overflow_err(ovf), .config_err(cfg), .spec_valid, .spec_data,
        .spec_ready, .res_valid, .res_data, .res_ready);
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // rearm in a mode; n counts ticks with output high, f is the first such tick
    task automatic run(input esp_mode_t m, input int ticks);
        @(posedge clock) arm <= 1'b0;
        mode <= m;
        repeat (4) @(posedge clock);
        arm <= 1'b1;
        n = 0;
        f = 0;
        for (int i = 1; i <= ticks; i++)
        begin
            pins.tick(1);
            #1 n += pulse_out;
            if (n == 1 && f == 0)
                f = i;
        end
    endtask : run
    initial
    begin
        repeat (100000) @(posedge clock);
        num_errors++;
        final_report();
    end
    initial
    begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        pins.pulse(0);
        pins.tick(2);
        run(esp_meas_single, 2);
        pins.pulse(0);
        pins.tick(2);
        pins.pulse(0);
        pins.tick(3);
        pins.pulse(1);
        check(last_count, 32'h5);
        check({res_valid, done, res_data}, {2'h3, 32'h5});
        @(posedge clock) res_ready <= 1'b1;
        @(posedge clock) res_ready <= 1'b0;
        pins.pulse(0);
        pins.tick(3);
        pins.pulse(1);
        check({res_valid, last_count}, 33'h5);
        dly <= 32'h2;
        hi <= 32'h3;
        run(esp_gen_single, 8);
        check({f[15:0], n[15:0], done}, {16'h2, 16'h3, 1'b1});
        dly <= 32'h0;
        hi <= 32'h2;
        lo <= 32'h3;
        run(esp_gen_cont, 20);
        check({f, n}, {32'h1, 32'h8});
        // gate idles low, so with a falling active level the pause holds throughout
        pz <= 1'b1;
        gr <= 1'b0;
        run(esp_gen_cont, 5);
        check(n, 32'h5);
        run(esp_gen_retrig, 1);
        check({cfg, busy}, 2'h2);
        pz <= 1'b0;
        gr <= 1'b1;
        pc <= 32'h3;
        run(esp_gen_finite, 20);
        check({n, done}, {32'h5, 1'b1});
        ust <= 1'b1;
        run(esp_gen_cont, 3);
        check(n, 32'h0);
        pins.pulse(1);
        check(pulse_out, 1'b1);
        @(posedge clock) arm <= 1'b0;
        mode <= esp_gen_buf_implicit;
        repeat (3) @(posedge clock);
        #1 check({pulse_out, busy}, 2'h0);
        @(posedge clock) spec_valid <= 1'b1;
        n = 0;
        // count the accepted words: ready seen before each edge that writes
        repeat (20)
        begin
            #1 n += spec_ready;
            @(posedge clock);
        end
        @(posedge clock) spec_valid <= 1'b0;
        check(n, 32'h10);
        run(esp_gen_buf_implicit, 40);
        check({n, und, done}, {32'h10, 2'h3});
        sr <= 1'b0;
        run(esp_meas_sampled, 0);
        pins.pulse(2);
        check(ovr, 1'b1);
        pins.pulse(0);
        pins.tick(2);
        pins.pulse(1);
        check(res_valid, 1'b0);
        pins.pulse(2);
        check({res_valid, res_data}, {1'b1, 32'h2});
        final_report();
    end
endmodule : tb_esp_counter
